/* File: src/fbm_host_ctrl.sv */
// host-side controller driving a parallel nor flash through its pins
// Summary of operation
// - reads use ce and oe low, we high
// - writes use we and ce low, oe high
// - wait reset-high-to-read before first read
// - after abort, host writes a valid command
// - restart operation interrupted by reset; there is no restart logic, and a hw reset is taken only between cycles
// - id unlock uses 555 and 2aa patterns
`timescale 1ns/10ps
`default_nettype none
`include "fbm_cfg.svh"
module fbm_host_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire fbm_pkg::fbm_op_t i_op,
  input wire logic [17:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_id_mode,
  output logic o_op_done_indicator_sync,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_reset_n,
  output logic [17:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [15:0] i_dq_in,
  input wire logic i_op_done_indicator
);
  import fbm_pkg::*;
  typedef enum logic [2:0] {
    HC_IDLE, HC_ISSUE, HC_WAIT, HC_RST_LOW, HC_RST_RDY, HC_RST_TRH
  } fbm_hc_t;
  fbm_cyc_if cyc ();
  fbm_hc_t st_ff;
  fbm_op_t op_ff;
  logic [17:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [1:0] step_ff;
  logic [4:0] tcnt_ff;
  logic [15:0] dq_meta_ff, dq_sync_ff;
  logic rdy_meta_ff, rdy_sync_ff;
  logic id_mode_ff;
  logic req_ff;
  // device pins reach us asynchronously
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dq_meta_ff <= 16'h0000;
      dq_sync_ff <= 16'h0000;
      rdy_meta_ff <= 1'b0;
      rdy_sync_ff <= 1'b0;
    end else begin
      dq_meta_ff <= i_dq_in;
      dq_sync_ff <= dq_meta_ff;
      rdy_meta_ff <= i_op_done_indicator;
      rdy_sync_ff <= rdy_meta_ff;
    end
  end
  // id entry is three writes; hw reset runs no bus cycle; other ops collapse to a single cycle
  wire [1:0] last_step = (op_ff == FBM_OP_ID_ENTER) ? 2'd2 : 2'd0;
  wire is_write = (op_ff == FBM_OP_WRITE) || (op_ff == FBM_OP_RESET_CMD) || (op_ff == FBM_OP_ID_ENTER);
  wire [17:0] id_unlock_addr = (step_ff == 2'd1) ? `FBM_UNLOCK2_ADDR : `FBM_UNLOCK1_ADDR;
  wire [15:0] id_unlock_data = (step_ff == 2'd0) ? `FBM_UNLOCK1_DATA :
                               (step_ff == 2'd1) ? `FBM_UNLOCK2_DATA : `FBM_ID_CMD;
  wire [17:0] cyc_addr = (op_ff == FBM_OP_ID_ENTER) ? id_unlock_addr :
                         (op_ff == FBM_OP_ID_MFR) ? `FBM_ID_MFR_ADDR :
                         (op_ff == FBM_OP_ID_DEV) ? `FBM_ID_DEV_ADDR : addr_ff;
  wire [15:0] cyc_wdata = (op_ff == FBM_OP_ID_ENTER) ? id_unlock_data :
                          (op_ff == FBM_OP_RESET_CMD) ? `FBM_RESET_CMD : wdata_ff;
  assign cyc.req = req_ff;
  assign cyc.wr = is_write;
  assign cyc.addr = cyc_addr;
  assign cyc.wdata = cyc_wdata;
  fbm_cycle_engine u_eng (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .cyc(cyc),
    .i_dq_sync(dq_sync_ff),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_addr(o_addr),
    .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe)
  );
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= HC_IDLE;
      op_ff <= FBM_OP_READ;
      addr_ff <= 18'h00000;
      wdata_ff <= 16'h0000;
      step_ff <= 2'd0;
      tcnt_ff <= 5'h00;
      id_mode_ff <= 1'b0;
      req_ff <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
      o_reset_n <= 1'b0;
      o_id_mode <= 1'b0;
      o_op_done_indicator_sync <= 1'b0;
    end else begin
      o_done <= 1'b0;
      req_ff <= 1'b0;
      o_id_mode <= id_mode_ff;
      o_op_done_indicator_sync <= rdy_sync_ff;
      case (st_ff)
        HC_IDLE: begin
          // first release of our own reset also pulses the device reset
          if (!o_reset_n) begin
            tcnt_ff <= 5'(`FBM_RESET_PULSE_MIN_CYC);
            o_busy <= 1'b1;
            st_ff <= HC_RST_LOW;
          end else if (i_req) begin
            op_ff <= i_op;
            addr_ff <= i_addr;
            wdata_ff <= i_wdata;
            step_ff <= 2'd0;
            o_busy <= 1'b1;
            if (i_op == FBM_OP_HW_RESET) begin
              // taken only between cycles, so no host cycle is cut and needs a restart
              o_reset_n <= 1'b0;
              tcnt_ff <= 5'(`FBM_RESET_PULSE_MIN_CYC);
              st_ff <= HC_RST_LOW;
            end else begin
              st_ff <= HC_ISSUE;
            end
          end
        end
        HC_ISSUE: begin
          req_ff <= 1'b1;
          st_ff <= HC_WAIT;
        end
        HC_WAIT: if (cyc.done) begin
          if (step_ff != last_step) begin
            step_ff <= step_ff + 2'd1;
            st_ff <= HC_ISSUE;
          end else begin
            if (op_ff == FBM_OP_ID_ENTER) id_mode_ff <= 1'b1;
            if (op_ff == FBM_OP_RESET_CMD) id_mode_ff <= 1'b0;
            o_rdata <= cyc.rdata;
            o_done <= 1'b1;
            // free for the next valid command
            o_busy <= 1'b0;
            st_ff <= HC_IDLE;
          end
        end
        HC_RST_LOW: begin
          // hold device reset for the minimum pulse
          if (tcnt_ff != 5'h00) tcnt_ff <= tcnt_ff - 5'h01;
          else begin
            o_reset_n <= 1'b1;
            id_mode_ff <= 1'b0;
            st_ff <= HC_RST_RDY;
          end
        end
        HC_RST_RDY: begin
          // busy low after an aborted algorithm: wait for it to clear
          if (rdy_sync_ff) begin
            tcnt_ff <= 5'(`FBM_RESET_HIGH_TO_READ_CYC);
            st_ff <= HC_RST_TRH;
          end
        end
        HC_RST_TRH: begin
          if (tcnt_ff != 5'h00) tcnt_ff <= tcnt_ff - 5'h01;
          else begin
            o_done <= 1'b1;
            o_busy <= 1'b0;
            st_ff <= HC_IDLE;
          end
        end
        default: st_ff <= HC_IDLE;
      endcase
    end
  end
  chk_reset_pulse_len: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(o_reset_n) |-> !o_reset_n [*8]) else $error("device reset pulse too short");
  // saturating length of the current device reset pulse, for the minimum-width check
  logic [4:0] rst_lo_len_ff;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_lo_len_ff <= 5'h00;
    end else if (o_reset_n) begin
      rst_lo_len_ff <= 5'h00;
    end else if (rst_lo_len_ff != 5'h1f) begin
      rst_lo_len_ff <= rst_lo_len_ff + 5'h01;
    end
  end
  chk_reset_pulse_min: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_reset_n) |-> rst_lo_len_ff >= 5'(`FBM_RESET_PULSE_MIN_CYC))
    else $error("device reset pulse under minimum");
  chk_no_cycle_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_reset_n |-> (o_ce_n && o_we_n && o_oe_n)) else $error("bus cycle during device reset");
  chk_read_after_rst: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_reset_n) |-> o_oe_n [*3]) else $error("read too soon after reset release");
  chk_id_mode_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff == HC_WAIT && cyc.done && op_ff == FBM_OP_ID_ENTER && step_ff == 2'd2) |=> ##1 o_id_mode)
    else $error("id mode not flagged");
  chk_reset_cmd_data: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!o_we_n && op_ff == FBM_OP_RESET_CMD) |-> o_dq_out == `FBM_RESET_CMD)
    else $error("reset command data wrong");
  chk_unlock_first: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!o_we_n && op_ff == FBM_OP_ID_ENTER && step_ff == 2'd0) |-> o_addr == `FBM_UNLOCK1_ADDR)
    else $error("unlock address wrong");
  chk_mfr_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!o_oe_n && op_ff == FBM_OP_ID_MFR) |-> o_addr[1:0] == 2'b00) else $error("maker code address wrong");
  chk_dev_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!o_oe_n && op_ff == FBM_OP_ID_DEV) |-> o_addr[1:0] == 2'b01) else $error("device code address wrong");
  cov_read: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_done && op_ff == FBM_OP_READ);
  cov_id_enter: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $rose(o_id_mode));
  cov_hw_reset: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $rose(o_reset_n));
  cov_write: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_done && op_ff == FBM_OP_WRITE);
  cov_rdy_wait: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) st_ff == HC_RST_RDY && !rdy_sync_ff);
endmodule : fbm_host_ctrl
`default_nettype wire

/* File: src/fbm_cfg.svh */
// timing counts and bus patterns for the flash bus controller
`ifndef FBM_CFG_SVH
`define FBM_CFG_SVH
`define FBM_CLK_PERIOD_NS 25
`define FBM_RESET_PULSE_MIN_NS 500
`define FBM_RESET_PULSE_MIN_CYC ((`FBM_RESET_PULSE_MIN_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_RESET_HIGH_TO_READ_NS 50
`define FBM_RESET_HIGH_TO_READ_CYC ((`FBM_RESET_HIGH_TO_READ_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_ACCESS_NS 90
`define FBM_ACCESS_CYC ((`FBM_ACCESS_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_WR_PULSE_NS 50
`define FBM_WR_PULSE_CYC ((`FBM_WR_PULSE_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_UNLOCK1_ADDR 18'h00555
`define FBM_UNLOCK2_ADDR 18'h002aa
`define FBM_UNLOCK1_DATA 16'h00aa
`define FBM_UNLOCK2_DATA 16'h0055
`define FBM_ID_CMD 16'h0090
`define FBM_RESET_CMD 16'h00f0
`define FBM_ID_MFR_ADDR 18'h00000
`define FBM_ID_DEV_ADDR 18'h00001
`endif

/* File: src/fbm_pkg.sv */
// types for the flash bus controller
package fbm_pkg;
  typedef enum logic [2:0] {
    FBM_OP_READ,
    FBM_OP_WRITE,
    FBM_OP_RESET_CMD,
    FBM_OP_ID_ENTER,
    FBM_OP_ID_MFR,
    FBM_OP_ID_DEV,
    FBM_OP_HW_RESET
  } fbm_op_t;
endpackage : fbm_pkg

/* File: src/fbm_cyc_if.sv */
// single-cycle bus request between sequencer and pin engine
`timescale 1ns/10ps
`default_nettype none
interface fbm_cyc_if;
  logic req;
  logic wr;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fbm_cyc_if
`default_nettype wire

/* File: src/fbm_cycle_engine.sv */
// one read or write cycle on the flash pins
`timescale 1ns/10ps
`default_nettype none
`include "fbm_cfg.svh"
module fbm_cycle_engine (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  fbm_cyc_if.eng cyc,
  input wire logic [15:0] i_dq_sync,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [17:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe
);
  import fbm_pkg::*;
  typedef enum logic [1:0] {ENG_IDLE, ENG_ACT, ENG_END} fbm_eng_t;
  fbm_eng_t st_ff, nxt_st;
  logic [3:0] cnt_ff;
  logic wr_ff;
  logic [15:0] rdata_ff;
  logic done_ff;
  wire cnt_exp = (cnt_ff == 4'h0);
  wire [3:0] load_cnt = cyc.wr ? 4'(`FBM_WR_PULSE_CYC) : 4'(`FBM_ACCESS_CYC + 2);
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ENG_IDLE: if (cyc.req) nxt_st = ENG_ACT;
      ENG_ACT: if (cnt_exp) nxt_st = ENG_END;
      ENG_END: nxt_st = ENG_IDLE;
      default: nxt_st = ENG_IDLE;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= ENG_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      done_ff <= 1'b0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_addr <= 18'h00000;
      o_dq_out <= 16'h0000;
      o_dq_oe <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      done_ff <= (st_ff == ENG_END);
      if (st_ff == ENG_IDLE && cyc.req) begin
        cnt_ff <= load_cnt;
        wr_ff <= cyc.wr;
        o_addr <= cyc.addr;
        o_dq_out <= cyc.wdata;
        o_ce_n <= 1'b0;
        // read: oe low, we high write: we low, oe high
        o_oe_n <= cyc.wr;
        o_we_n <= !cyc.wr;
        o_dq_oe <= cyc.wr;
      end else if (st_ff == ENG_ACT) begin
        if (!cnt_exp) cnt_ff <= cnt_ff - 4'h1;
        else begin
          // strobes rise together; data held one more cycle past the rising edge
          o_we_n <= 1'b1;
          o_oe_n <= 1'b1;
          o_ce_n <= 1'b1;
          if (!wr_ff) rdata_ff <= i_dq_sync;
        end
      end else if (st_ff == ENG_END) begin
        o_dq_oe <= 1'b0;
      end
    end
  end
  assign cyc.done = done_ff;
  assign cyc.rdata = rdata_ff;
  chk_write_strobes: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_we_n |-> (!o_ce_n && o_oe_n && o_dq_oe)) else $error("write strobe without ce or with oe");
  chk_read_strobes: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_oe_n |-> (!o_ce_n && o_we_n && !o_dq_oe)) else $error("read gate with we low or bus driven");
endmodule : fbm_cycle_engine
`default_nettype wire

/* File: sim/fbm_flash_model.sv */
// behavioural parallel nor flash: array read, unlock decode, identity mode
`timescale 1ns/10ps
`default_nettype none
module fbm_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h3c, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h1e47, // arbitrary value
  parameter int ACC_NS = 0,
  parameter int RCV_NS = 0
) (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_reset_n,
  input wire logic [17:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_ready
);
  logic [1:0] seq = 2'h0;
  logic id_on = 1'b0;
  logic wr_open = 1'b0;
  logic [17:0] lat_a = 18'h00000;
  logic [15:0] last = 16'h0000;
  wire logic drive;
  wire logic [15:0] rd_val;
  logic rcv_busy = 1'b0;
  // every reset is treated as cutting an algorithm, so the host must watch the pin
  assign o_ready = !rcv_busy;
  // recovery runs on whatever chip select does
  always @(i_reset_n) begin
    if (i_reset_n !== 1'b1) begin
      rcv_busy = 1'b1;
    end else begin
      #(RCV_NS) rcv_busy = 1'b0;
    end
  end
  assign drive = !i_ce_n && !i_oe_n && i_reset_n;
  assign rd_val = !id_on ? (i_addr[15:0] ^ 16'h5a5a) :
    (i_addr[1:0] == 2'h0) ? {8'h00, MFR_CODE} :
    (i_addr[1:0] == 2'h1) ? DEV_CODE : 16'h0000;
  always @(drive or rd_val) begin
    if (drive) begin
      last = rd_val;
    end
  end
  // released bus shows the inverse of the last value, never a kind constant
  assign #(ACC_NS) o_dq = drive ? rd_val : ~last;
  always @(negedge i_we_n or negedge i_ce_n) begin
    if (!i_we_n && !i_ce_n && i_reset_n) begin
      lat_a = i_addr;
      wr_open = 1'b1;
    end
  end
  always @(posedge i_we_n or posedge i_ce_n or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seq = 2'h0;
      id_on = 1'b0;
      wr_open = 1'b0;
    end else if (wr_open) begin
      wr_open = 1'b0;
      if (i_dq[7:0] == 8'hf0) begin
        seq = 2'h0;
        id_on = 1'b0;
      end else if (seq == 2'h0 && lat_a[10:0] == 11'h555 && i_dq[7:0] == 8'haa) begin
        seq = 2'h1;
      end else if (seq == 2'h1 && lat_a[10:0] == 11'h2aa && i_dq[7:0] == 8'h55) begin
        seq = 2'h2;
      end else if (seq == 2'h2 && lat_a[10:0] == 11'h555 && i_dq[7:0] == 8'h90) begin
        seq = 2'h0;
        id_on = 1'b1;
      end else begin
        seq = 2'h0;
      end
    end
  end
endmodule : fbm_flash_model
`default_nettype wire

/* File: sim/fbm_host_ctrl_test.sv */
// self-checking bench for the flash bus controller against the flash model
`timescale 1ns/10ps
`default_nettype none
`include "fbm_cfg.svh"
module fbm_host_ctrl_test;
  import fbm_pkg::*;
  localparam logic [7:0] MFR = 8'h3c; // arbitrary value
  localparam logic [15:0] DEV = 16'h1e47; // arbitrary value
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_req = 1'b0;
  fbm_op_t i_op = FBM_OP_READ;
  logic [17:0] i_addr = 18'h00000;
  logic [15:0] i_wdata = 16'h0000;
  logic o_busy, o_done, o_id_mode, o_rdy_sync, o_ce_n, o_oe_n, o_we_n, o_reset_n, o_dq_oe, rdy;
  logic [15:0] o_rdata, o_dq_out, m_dq, dq_in;
  logic [17:0] o_addr;
  int n_fail = 0;
  int checks = 0;
  int lo_cnt = 0;
  int hi_cnt = 0;
  logic prev_oe = 1'b1;
  assign dq_in = o_dq_oe ? o_dq_out : m_dq;
  always #12.5 i_ref_clk = ~i_ref_clk;
  fbm_host_ctrl dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_op(i_op), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_id_mode(o_id_mode),
    .o_op_done_indicator_sync(o_rdy_sync), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
    .o_reset_n(o_reset_n), .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(dq_in),
    .i_op_done_indicator(rdy));
  // slow access so the host's sampling point is exercised
  fbm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .ACC_NS(70), .RCV_NS(400)) flash (.i_ce_n(o_ce_n),
    .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_reset_n(o_reset_n), .i_addr(o_addr), .i_dq(dq_in), .o_dq(m_dq),
    .o_ready(rdy));
  function automatic logic [15:0] arr(input logic [17:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction : arr
  task automatic print_verdict;
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_done !== 1'b1 && n < 3000);
    if (o_done !== 1'b1) begin
      n_fail++;
      $display("[ERR] o_done expected 1 seen none");
      print_verdict();
    end
  endtask : wait_done
  task automatic do_op(input fbm_op_t op, input logic [17:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_req <= 1'b1;
    i_op <= op;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
    @(negedge i_ref_clk);
    check("o_busy", o_busy, 1'b1);
    wait_done();
    check("o_busy", o_busy, 1'b0);
    // id mode flag follows done by one cycle
    @(negedge i_ref_clk);
  endtask : do_op
  // pin-level watch: strobe combinations and reset timing
  always @(negedge i_ref_clk) begin
    if (!o_oe_n && prev_oe) begin
      check("o_we_n", o_we_n, 1'b1);
      check("ready_at_read", rdy, 1'b1);
      check("reset_high_gap", hi_cnt > `FBM_RESET_HIGH_TO_READ_CYC, 1'b1);
    end
    if (!o_we_n) check("o_oe_n", o_oe_n, 1'b1);
    if (o_reset_n === 1'b1 && lo_cnt > 0) check("reset_low_len", lo_cnt >= `FBM_RESET_PULSE_MIN_CYC, 1'b1);
    lo_cnt = (o_reset_n === 1'b1) ? 0 : lo_cnt + 1;
    hi_cnt = (o_reset_n === 1'b1) ? hi_cnt + 1 : 0;
    prev_oe = o_oe_n;
  end
  task automatic t_power_read;
    check("o_op_done_indicator_sync", o_rdy_sync, 1'b1);
    check("o_id_mode", o_id_mode, 1'b0);
    do_op(FBM_OP_READ, 18'h00000, 16'h0000);
    check("o_rdata", o_rdata, arr(18'h00000));
    do_op(FBM_OP_READ, 18'h3ffff, 16'h0000);
    check("o_rdata", o_rdata, arr(18'h3ffff));
    do_op(FBM_OP_READ, 18'h01234, 16'h0000);
    check("o_rdata", o_rdata, arr(18'h01234));
  endtask : t_power_read
  task automatic t_id_mode;
    do_op(FBM_OP_ID_ENTER, 18'h00000, 16'h0000);
    check("o_id_mode", o_id_mode, 1'b1);
    do_op(FBM_OP_ID_MFR, 18'h00000, 16'h0000);
    check("mfr_code", o_rdata, {8'h00, MFR});
    do_op(FBM_OP_ID_DEV, 18'h00000, 16'h0000);
    check("dev_code", o_rdata, DEV);
    do_op(FBM_OP_READ, 18'h00001, 16'h0000);
    check("o_rdata", o_rdata, DEV);
    do_op(FBM_OP_RESET_CMD, 18'h00000, 16'h0000);
    check("o_id_mode", o_id_mode, 1'b0);
    do_op(FBM_OP_READ, 18'h00001, 16'h0000);
    check("o_rdata", o_rdata, arr(18'h00001));
  endtask : t_id_mode
  task automatic t_bad_seq;
    do_op(FBM_OP_WRITE, 18'h00555, 16'h00aa);
    do_op(FBM_OP_WRITE, 18'h002aa, 16'h0055);
    // address one off breaks the unlock
    do_op(FBM_OP_WRITE, 18'h00556, 16'h0090);
    do_op(FBM_OP_READ, 18'h00000, 16'h0000);
    check("o_rdata", o_rdata, arr(18'h00000));
    do_op(FBM_OP_WRITE, 18'h00555, 16'h00aa);
    do_op(FBM_OP_WRITE, 18'h002aa, 16'h0055);
    do_op(FBM_OP_WRITE, 18'h00555, 16'h0090);
    do_op(FBM_OP_READ, 18'h00000, 16'h0000);
    check("o_rdata", o_rdata, {8'h00, MFR});
    do_op(FBM_OP_RESET_CMD, 18'h00000, 16'h0000);
  endtask : t_bad_seq
  task automatic t_hw_reset;
    do_op(FBM_OP_ID_ENTER, 18'h00000, 16'h0000);
    do_op(FBM_OP_HW_RESET, 18'h00000, 16'h0000);
    check("o_id_mode", o_id_mode, 1'b0);
    check("o_op_done_indicator_sync", o_rdy_sync, 1'b1);
    do_op(FBM_OP_READ, 18'h00001, 16'h0000);
    check("o_rdata", o_rdata, arr(18'h00001));
  endtask : t_hw_reset
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    wait_done();
    t_power_read();
    t_id_mode();
    t_bad_seq();
    t_hw_reset();
    print_verdict();
  end
endmodule : fbm_host_ctrl_test
`default_nettype wire
